//--- logic/stact_fsm.sv
// Purpose: layer-1 activation machine, exchange side and network termination
// Assumes: line receiver flags are asynchronous; link frames far slower than ref_clk_i
// Notes:   commands cross from link to core by toggle, indications back by toggle handshake
//
// Overview of operation
// - deactivation request sends INFO 0; any state except the wait-for-confirm state in termination mode
// - reset command resets machine, INFO 0, ignores line
// - pulse test commands enter test states from anywhere
// - activation request command starts exchange activation
// - loop request closes analog loop near line
// - deactivation confirm enters deactivated, wake detection enabled
// - exchange mode reports timing while deactivated
// - termination mode reports timing during deactivation
// - report unsynchronised when pending with signal but no sync, or framing lost
// - termination mode reports activation request on wake signal while deactivated
// - code violation reported only when enabled
// - synchronous and active reports activation indication
// - deactivation ends after 16 ms quiet or 32 ms
// - deactivated sends nothing, stops clocks if configured
// - termination mode holds wake state until activation command or deactivation request
// - pending state sends INFO 2, loop on request
// - termination mode keeps INFO 2 until switch-through
// - switch-through sends INFO 4, transparent; loop variant
// - sync loss while active enters lost framing
// - termination mode: upstream loss command while active enters upstream lost framing
// - wait state holds until deactivation confirm
// - exchange mode resumes INFO 4 after INFO 3
// - pending entered by command, or by wake signal in exchange mode
module stact_fsm #(
  parameter int QUIET_CYC_P = stact_pkg::QUIET_CYC,
  parameter int DEACT_CYC_P = stact_pkg::DEACT_CYC
) (
  // core clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // control link
  input  wire logic       lnk_clk_i,
  input  wire logic       lnk_frame_i,
  input  wire logic [3:0] lnk_cmd_i,
  output logic      [3:0] lnk_ind_o,
  // configuration
  input  wire logic       net_term_mode_i,
  input  wire logic       code_violation_enable_i,
  input  wire logic       clock_switch_off_bit_i,
  // line receiver
  input  wire logic       rx_info0_i,
  input  wire logic       rx_level_i,
  input  wire logic       rx_info3_i,
  input  wire logic       rx_sync_i,
  input  wire logic       rx_code_viol_i,
  // line transmitter and loops
  output logic      [2:0] tx_info_o,
  output logic            loop_close_o,
  output logic            transparent_o,
  output logic            clk_stop_o,
  output logic            wake_det_en_o
);

  stact_pkg::stact_state_type state_r;
  stact_pkg::stact_state_type state_nxt;

  logic [4:0]                 rx_meta_r;
  logic [4:0]                 rx_s_r;
  logic                       info0_s;
  logic                       level_s;
  logic                       info3_s;
  logic                       sync_s;
  logic                       cviol_s;
  logic [3:0]                 cmd_r;
  logic                       ct_meta_r;
  logic                       ct_s_r;
  logic                       ct_d_r;
  logic [3:0]                 ind_hold_r;
  logic [3:0]                 ind_nxt;
  logic                       ind_tgl_r;
  logic                       ack_meta_r;
  logic                       ack_s_r;
  logic                       cvr_r;
  logic [stact_pkg::TMR_W-1:0] quiet_r;
  logic [stact_pkg::TMR_W-1:0] tmr_r;
  logic                       quiet_done;
  logic                       tmr_done;
  logic                       uncond;
  // link domain
  logic                       lrst_meta_r;
  logic                       lrst_r;
  logic [3:0]                 lcmd_prev_r;
  logic [3:0]                 lcmd_stable_r;
  logic                       lcmd_tgl_r;
  logic                       lit_meta_r;
  logic                       lit_s_r;
  logic                       lit_d_r;
  logic                       lack_tgl_r;

  assign {info0_s, level_s, info3_s, sync_s, cviol_s} = rx_s_r;

  // ---------------- link domain ----------------
  // reset only reaches this side while the link clock runs
  always_ff @(posedge lnk_clk_i) begin
    lrst_meta_r <= srst_i;
    lrst_r      <= lrst_meta_r;
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lrst_r) begin
      lcmd_prev_r   <= stact_pkg::CMD_FSM_RESET;
      lcmd_stable_r <= stact_pkg::CMD_FSM_RESET;
      lcmd_tgl_r    <= 1'b0;
    end else if (lnk_frame_i) begin
      lcmd_prev_r <= lnk_cmd_i;
      if (lnk_cmd_i == lcmd_prev_r && lnk_cmd_i != lcmd_stable_r) begin
        lcmd_stable_r <= lnk_cmd_i;
        lcmd_tgl_r    <= ~lcmd_tgl_r;
      end
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lrst_r) begin
      lit_meta_r <= 1'b0;
      lit_s_r    <= 1'b0;
      lit_d_r    <= 1'b0;
      lack_tgl_r <= 1'b0;
      lnk_ind_o  <= stact_pkg::IND_FSM_RESET;
    end else begin
      lit_meta_r <= ind_tgl_r;
      lit_s_r    <= lit_meta_r;
      lit_d_r    <= lit_s_r;
      if (lit_s_r != lit_d_r) begin
        lnk_ind_o  <= ind_hold_r;
        lack_tgl_r <= lit_s_r;
      end
    end
  end

  // ---------------- core domain ----------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_meta_r <= 5'h00;
      rx_s_r    <= 5'h00;
    end else begin
      rx_meta_r <= {rx_info0_i, rx_level_i, rx_info3_i, rx_sync_i, rx_code_viol_i};
      rx_s_r    <= rx_meta_r;
    end
  end

  // link word is held steady for two frames, far longer than this crossing
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ct_meta_r <= 1'b0;
      ct_s_r    <= 1'b0;
      ct_d_r    <= 1'b0;
      cmd_r     <= stact_pkg::CMD_FSM_RESET;
    end else begin
      ct_meta_r <= lcmd_tgl_r;
      ct_s_r    <= ct_meta_r;
      ct_d_r    <= ct_s_r;
      if (ct_s_r != ct_d_r) begin
        cmd_r <= lcmd_stable_r;
      end
    end
  end

  assign uncond = (cmd_r == stact_pkg::CMD_FSM_RESET) || (cmd_r == stact_pkg::CMD_SINGLE_PULSE)
                || (cmd_r == stact_pkg::CMD_CONT_PULSE);
  assign quiet_done = quiet_r == stact_pkg::TMR_W'(QUIET_CYC_P - 1);
  assign tmr_done   = tmr_r == stact_pkg::TMR_W'(DEACT_CYC_P - 1);

  always_comb begin
    state_nxt = state_r;
    if (cmd_r == stact_pkg::CMD_FSM_RESET) begin
      state_nxt = stact_pkg::ST_RESET;
    end else if (cmd_r == stact_pkg::CMD_SINGLE_PULSE) begin
      state_nxt = stact_pkg::ST_SINGLE;
    end else if (cmd_r == stact_pkg::CMD_CONT_PULSE) begin
      state_nxt = stact_pkg::ST_CONT;
    end else if (cmd_r == stact_pkg::CMD_DEACT_REQ && state_r != stact_pkg::ST_PDEACT
                 && state_r != stact_pkg::ST_WAIT_DC && (net_term_mode_i
                 || (state_r != stact_pkg::ST_DEACT && state_r != stact_pkg::ST_RESET))) begin
      state_nxt = stact_pkg::ST_PDEACT;
    end else begin
      case (state_r)
        stact_pkg::ST_RESET, stact_pkg::ST_SINGLE, stact_pkg::ST_CONT: begin
          if (cmd_r == stact_pkg::CMD_DEACT_CONFIRM) state_nxt = stact_pkg::ST_DEACT;
        end
        stact_pkg::ST_DEACT: begin
          if (cmd_r == stact_pkg::CMD_ACT_REQ || cmd_r == stact_pkg::CMD_ACT_REQ_LOOP) begin
            state_nxt = stact_pkg::ST_PEND;
          end else if (level_s) begin
            state_nxt = net_term_mode_i ? stact_pkg::ST_WAKE_SEEN : stact_pkg::ST_PEND;
          end
        end
        stact_pkg::ST_WAKE_SEEN: begin
          if (cmd_r == stact_pkg::CMD_ACT_REQ || cmd_r == stact_pkg::CMD_ACT_REQ_LOOP) begin
            state_nxt = stact_pkg::ST_PEND;
          end
        end
        stact_pkg::ST_PEND: begin
          if (info3_s && sync_s) begin
            state_nxt = net_term_mode_i ? stact_pkg::ST_WAIT_SW : stact_pkg::ST_ACT;
          end
        end
        stact_pkg::ST_WAIT_SW, stact_pkg::ST_LOST_UP: begin
          if (cmd_r == stact_pkg::CMD_SWITCH_THROUGH || cmd_r == stact_pkg::CMD_ACT_IND_LOOP) begin
            state_nxt = stact_pkg::ST_ACT;
          end
        end
        stact_pkg::ST_ACT: begin
          if (!sync_s) begin
            state_nxt = stact_pkg::ST_LOST_ST;
          end else if (net_term_mode_i && cmd_r == stact_pkg::CMD_UPSTREAM_LOST) begin
            state_nxt = stact_pkg::ST_LOST_UP;
          end
        end
        stact_pkg::ST_LOST_ST: begin
          if (info3_s && sync_s) state_nxt = stact_pkg::ST_ACT;
        end
        stact_pkg::ST_PDEACT: begin
          if ((info0_s && quiet_done) || tmr_done) state_nxt = stact_pkg::ST_WAIT_DC;
        end
        stact_pkg::ST_WAIT_DC: begin
          if (cmd_r == stact_pkg::CMD_DEACT_CONFIRM) state_nxt = stact_pkg::ST_DEACT;
        end
        default: state_nxt = stact_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) state_r <= stact_pkg::ST_RESET;
    else        state_r <= state_nxt;
  end

  // both timers run only inside pending deactivation
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || state_r != stact_pkg::ST_PDEACT) begin
      quiet_r <= '0;
      tmr_r   <= '0;
    end else begin
      quiet_r <= (info0_s && !quiet_done) ? quiet_r + 1'b1 : '0;
      tmr_r   <= tmr_done ? tmr_r : tmr_r + 1'b1;
    end
  end

  // violation stays reported until its indication reached the link
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cvr_r <= 1'b0;
    end else if (state_r == stact_pkg::ST_ACT && code_violation_enable_i && cviol_s) begin
      cvr_r <= 1'b1;
    end else if (state_r != stact_pkg::ST_ACT || !code_violation_enable_i
                 || (ind_hold_r == stact_pkg::IND_CODE_VIOL && ack_s_r == ind_tgl_r)) begin
      cvr_r <= 1'b0;
    end
  end

  always_comb begin
    case (state_r)
      stact_pkg::ST_RESET:     ind_nxt = stact_pkg::IND_FSM_RESET;
      stact_pkg::ST_DEACT:     ind_nxt = net_term_mode_i ? stact_pkg::IND_DEACT_IND
                                                         : stact_pkg::IND_TIMING;
      stact_pkg::ST_WAKE_SEEN: ind_nxt = stact_pkg::IND_ACT_REQ;
      stact_pkg::ST_PEND, stact_pkg::ST_WAIT_SW:
        ind_nxt = (level_s && !sync_s) ? stact_pkg::IND_RX_UNSYNC
                                       : stact_pkg::IND_ACT_REQ;
      stact_pkg::ST_ACT:       ind_nxt = cvr_r ? stact_pkg::IND_CODE_VIOL
                                               : stact_pkg::IND_ACT_IND;
      stact_pkg::ST_LOST_ST, stact_pkg::ST_LOST_UP:
        ind_nxt = stact_pkg::IND_RX_UNSYNC;
      stact_pkg::ST_PDEACT:    ind_nxt = stact_pkg::IND_TIMING;
      stact_pkg::ST_WAIT_DC:   ind_nxt = stact_pkg::IND_DEACT_IND;
      default:                 ind_nxt = stact_pkg::IND_TIMING;
    endcase
  end

  // a new code is launched only after the link took the last one
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_meta_r <= 1'b0;
      ack_s_r    <= 1'b0;
      ind_tgl_r  <= 1'b0;
      ind_hold_r <= stact_pkg::IND_FSM_RESET;
    end else begin
      ack_meta_r <= lack_tgl_r;
      ack_s_r    <= ack_meta_r;
      if (ack_s_r == ind_tgl_r && ind_nxt != ind_hold_r) begin
        ind_hold_r <= ind_nxt;
        ind_tgl_r  <= ~ind_tgl_r;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_info_o     <= stact_pkg::TX_INFO0;
      loop_close_o  <= 1'b0;
      transparent_o <= 1'b0;
      clk_stop_o    <= 1'b0;
      wake_det_en_o <= 1'b0;
    end else begin
      case (state_r)
        stact_pkg::ST_PEND, stact_pkg::ST_WAIT_SW, stact_pkg::ST_LOST_ST,
        stact_pkg::ST_LOST_UP: tx_info_o <= stact_pkg::TX_INFO2;
        stact_pkg::ST_ACT:     tx_info_o <= stact_pkg::TX_INFO4;
        stact_pkg::ST_SINGLE:  tx_info_o <= stact_pkg::TX_SINGLE_PULSE;
        stact_pkg::ST_CONT:    tx_info_o <= stact_pkg::TX_CONT_PULSE;
        default:               tx_info_o <= stact_pkg::TX_INFO0;
      endcase
      loop_close_o  <= (state_r == stact_pkg::ST_PEND && cmd_r == stact_pkg::CMD_ACT_REQ_LOOP)
                    || (state_r == stact_pkg::ST_ACT && (cmd_r == stact_pkg::CMD_ACT_IND_LOOP
                    || cmd_r == stact_pkg::CMD_ACT_REQ_LOOP));
      transparent_o <= state_r == stact_pkg::ST_ACT;
      clk_stop_o    <= state_r == stact_pkg::ST_DEACT && clock_switch_off_bit_i;
      wake_det_en_o <= state_r == stact_pkg::ST_DEACT;
    end
  end

  // ---------------- checks ----------------
  chk_reset_cmd_tx: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_r == stact_pkg::CMD_FSM_RESET |=> ##1 tx_info_o == stact_pkg::TX_INFO0)
    else $error("reset command did not force INFO 0");

  chk_pulse_entry: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_r == stact_pkg::CMD_CONT_PULSE |=> state_r == stact_pkg::ST_CONT
      ##1 tx_info_o == stact_pkg::TX_CONT_PULSE)
    else $error("continuous pulse test not entered");

  chk_term_deact_any: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    net_term_mode_i && cmd_r == stact_pkg::CMD_DEACT_REQ && state_r != stact_pkg::ST_WAIT_DC
      |=> state_r == stact_pkg::ST_PDEACT || state_r == stact_pkg::ST_WAIT_DC)
    else $error("deactivation request ignored");

  chk_deact_timer: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_PDEACT && !uncond && tmr_done |=> state_r == stact_pkg::ST_WAIT_DC
      ##1 ind_nxt == stact_pkg::IND_DEACT_IND)
    else $error("32 ms supervision did not end deactivation");

  chk_quiet_early: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_PDEACT && $past(state_r) == stact_pkg::ST_PDEACT && !info0_s
      && !tmr_done |=> state_r != stact_pkg::ST_WAIT_DC || uncond)
    else $error("deactivation ended without quiet line");

  chk_wait_holds: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_WAIT_DC && (cmd_r == stact_pkg::CMD_ACT_REQ
      || cmd_r == stact_pkg::CMD_DEACT_REQ) |=> state_r == stact_pkg::ST_WAIT_DC)
    else $error("wait state left without confirmation");

  chk_sync_loss: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_ACT && !sync_s && cmd_r == stact_pkg::CMD_SWITCH_THROUGH
      |=> state_r == stact_pkg::ST_LOST_ST ##1 tx_info_o == stact_pkg::TX_INFO2)
    else $error("sync loss not handled");

  chk_wake_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_WAKE_SEEN && cmd_r == stact_pkg::CMD_DEACT_CONFIRM
      |=> state_r == stact_pkg::ST_WAKE_SEEN)
    else $error("wake state left without activation command");

  chk_cvr_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !code_violation_enable_i |=> !cvr_r)
    else $error("violation reported while disabled");

  chk_clk_stop: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    clk_stop_o |-> $past(state_r) == stact_pkg::ST_DEACT && tx_info_o == stact_pkg::TX_INFO0)
    else $error("clocks stopped outside deactivated state");

  cov_activate: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_PEND ##1 state_r == stact_pkg::ST_ACT);
  cov_wait_dc: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_PDEACT ##1 state_r == stact_pkg::ST_WAIT_DC);
  cov_lost_up: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_LOST_UP);
  cov_wake: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    state_r == stact_pkg::ST_WAKE_SEEN ##1 state_r == stact_pkg::ST_PEND);

endmodule : stact_fsm

//--- logic/stact_pkg.sv
// Purpose: constants and types of the S/T activation state machine
// Assumes: reference clock of 20 MHz
// Notes:   command and indication codes are 4-bit channel values
package stact_pkg;

  // commands from the upstream controller
  localparam logic [3:0] CMD_DEACT_REQ      = 4'h0;
  localparam logic [3:0] CMD_FSM_RESET      = 4'h1;
  localparam logic [3:0] CMD_SINGLE_PULSE   = 4'h2;
  localparam logic [3:0] CMD_CONT_PULSE     = 4'h3;
  localparam logic [3:0] CMD_UPSTREAM_LOST  = 4'h4;
  localparam logic [3:0] CMD_ACT_REQ        = 4'h8;
  localparam logic [3:0] CMD_ACT_REQ_LOOP   = 4'ha;
  localparam logic [3:0] CMD_SWITCH_THROUGH = 4'hc;
  localparam logic [3:0] CMD_ACT_IND_LOOP   = 4'he;
  localparam logic [3:0] CMD_DEACT_CONFIRM  = 4'hf;

  // indications to the upstream controller
  localparam logic [3:0] IND_TIMING         = 4'h0;
  localparam logic [3:0] IND_FSM_RESET      = 4'h1;
  localparam logic [3:0] IND_RX_UNSYNC      = 4'h4;
  localparam logic [3:0] IND_ACT_REQ        = 4'h8;
  localparam logic [3:0] IND_CODE_VIOL      = 4'hb;
  localparam logic [3:0] IND_ACT_IND        = 4'hc;
  localparam logic [3:0] IND_DEACT_IND      = 4'hf;

  // line transmit selection
  localparam logic [2:0] TX_INFO0           = 3'h0;
  localparam logic [2:0] TX_INFO2           = 3'h1;
  localparam logic [2:0] TX_INFO4           = 3'h2;
  localparam logic [2:0] TX_SINGLE_PULSE    = 3'h3;
  localparam logic [2:0] TX_CONT_PULSE      = 3'h4;

  // deactivation supervision
  localparam int         REF_CLK_KHZ        = 20000;
  localparam int         QUIET_MS           = 16;
  localparam int         DEACT_MS           = 32;
  localparam int         QUIET_CYC          = QUIET_MS * REF_CLK_KHZ;
  localparam int         DEACT_CYC          = DEACT_MS * REF_CLK_KHZ;
  localparam int         TMR_W              = 20;

  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_DEACT     = 4'h1,
    ST_WAKE_SEEN = 4'h3,
    ST_PEND      = 4'h2,
    ST_WAIT_SW   = 4'h6,
    ST_ACT       = 4'h7,
    ST_LOST_ST   = 4'h5,
    ST_LOST_UP   = 4'h4,
    ST_PDEACT    = 4'hc,
    ST_WAIT_DC   = 4'hd,
    ST_SINGLE    = 4'hf,
    ST_CONT      = 4'he
  } stact_state_type;

endpackage : stact_pkg

//--- verification/stact_ctrl_model.sv
// Purpose: upstream controller model on the command link
// Assumes: link clock runs free, one frame every four link cycles
// Notes:   off-frame command lines churn so stale codes are never seen as valid
module stact_ctrl_model (
  // link towards the device
  output logic       lnk_clk_o,
  output logic       lnk_frame_o,
  output logic [3:0] lnk_cmd_o,
  // command chosen by the bench
  input  wire logic [3:0] cmd_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] slot_r;

  initial begin
    lnk_clk_o   = 1'b0;
    lnk_frame_o = 1'b0;
    lnk_cmd_o   = 4'h0;
    slot_r      = 2'h0;
  end

  always #7.5 lnk_clk_o = ~lnk_clk_o;

  // same code repeated every frame until the bench changes it
  always @(posedge lnk_clk_o) begin
    slot_r      <= slot_r + 2'h1;
    lnk_frame_o <= (slot_r == 2'h3);
    lnk_cmd_o   <= (slot_r == 2'h3) ? cmd_i : ~lnk_cmd_o;
  end
endmodule : stact_ctrl_model

//--- verification/stact_fsm_test.sv
// Purpose: self-checking bench of the activation machine
// Assumes: shortened supervision counts of 20 and 40 cycles
// Notes:   table rows first, then refusal, violation and timer cases
module stact_fsm_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic       ref_clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       lnk_clk_i;
  logic       lnk_frame_i;
  logic [3:0] lnk_cmd_i;
  logic [3:0] lnk_ind_o;
  logic       net_term_mode_i = 1'b0;
  logic       code_violation_enable_i = 1'b0;
  logic       clock_switch_off_bit_i = 1'b1;
  logic       rx_info0_i = 1'b0;
  logic       rx_level_i = 1'b0;
  logic       rx_info3_i = 1'b0;
  logic       rx_sync_i = 1'b0;
  logic       rx_code_viol_i = 1'b0;
  logic [2:0] tx_info_o;
  logic       loop_close_o;
  logic       transparent_o;
  logic       clk_stop_o;
  logic       wake_det_en_o;
  logic [3:0] cmd_q = 4'h1;
  int         mismatches = 0;
  int         tests_run = 0;
  bit         hit;
  // row: mode, cmd, rx {info0,level,info3,sync}, tx, ind, flags, mask
  // flags {loop, transparent, wake enable, clock stop}
  logic [27:0] rows [22] = '{
    28'h0f8003f, 28'h084140c, 28'h0832c4c, 28'h084140c,
    28'h0832c4c, 28'h0a32ccc, 28'h0080f0c, 28'h0f8003f,
    28'h028300c, 28'h038400c, 28'h018010f, 28'h0f8003f,
    28'h01f00f3f, 28'h01f4080c, 28'h0184140c, 28'h0183180c,
    28'h01c32c4c, 28'h01e32ccc, 28'h01431404, 28'h01c32c4c,
    28'h01080f0c, 28'h01f00f3f};

  always #25 ref_clk_i = ~ref_clk_i;

  stact_ctrl_model ctrl (
    .lnk_clk_o  (lnk_clk_i),
    .lnk_frame_o(lnk_frame_i),
    .lnk_cmd_o  (lnk_cmd_i),
    .cmd_i      (cmd_q)
  );

  stact_fsm #(.QUIET_CYC_P(20), .DEACT_CYC_P(40)) dut (
    .ref_clk_i              (ref_clk_i),
    .srst_i                 (srst_i),
    .lnk_clk_i              (lnk_clk_i),
    .lnk_frame_i            (lnk_frame_i),
    .lnk_cmd_i              (lnk_cmd_i),
    .lnk_ind_o              (lnk_ind_o),
    .net_term_mode_i        (net_term_mode_i),
    .code_violation_enable_i(code_violation_enable_i),
    .clock_switch_off_bit_i (clock_switch_off_bit_i),
    .rx_info0_i             (rx_info0_i),
    .rx_level_i             (rx_level_i),
    .rx_info3_i             (rx_info3_i),
    .rx_sync_i              (rx_sync_i),
    .rx_code_viol_i         (rx_code_viol_i),
    .tx_info_o              (tx_info_o),
    .loop_close_o           (loop_close_o),
    .transparent_o          (transparent_o),
    .clk_stop_o             (clk_stop_o),
    .wake_det_en_o          (wake_det_en_o)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // bounded wait for an indication value on the link
  task automatic see(input logic [3:0] v, input int n, output bit got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(negedge ref_clk_i);
      got = (lnk_ind_o === v);
    end
  endtask : see

  task automatic do_reset(input logic nt);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    net_term_mode_i <= nt;
    cmd_q = 4'h1;
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    see(4'h1, 4, hit);
    chk({7'h0, hit}, 8'h01);
  endtask : do_reset

  task automatic test_done;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    mismatches++;
    test_done();
  end

  initial begin
    logic [27:0] r;
    foreach (rows[i]) begin
      r = rows[i];
      if (i == 0 || r[24] !== net_term_mode_i) do_reset(r[24]);
      @(posedge ref_clk_i);
      {rx_info0_i, rx_level_i, rx_info3_i, rx_sync_i} <= r[19:16];
      cmd_q = r[23:20];
      for (int k = 0; k < 400; k++) begin
        @(negedge ref_clk_i);
        // loop commands change only flags, so wait for those as well
        if (tx_info_o === r[14:12] && lnk_ind_o === r[11:8]
            && ({loop_close_o, transparent_o, wake_det_en_o, clk_stop_o} & r[3:0])
               === (r[7:4] & r[3:0])) break;
      end
      repeat (3) @(negedge ref_clk_i);
      chk({5'h0, tx_info_o}, {5'h0, r[14:12]});
      chk({4'h0, lnk_ind_o}, {4'h0, r[11:8]});
      chk({4'h0, {loop_close_o, transparent_o, wake_det_en_o, clk_stop_o} & r[3:0]},
          {4'h0, r[7:4] & r[3:0]});
      $display("row %0d done", i);
    end
    do_reset(1'b0);
    cmd_q = 4'hf;
    see(4'h0, 200, hit);
    // one frame of a new code alone must not be taken
    @(posedge lnk_clk_i iff lnk_frame_i);
    cmd_q = 4'h8;
    @(posedge lnk_clk_i iff lnk_frame_i);
    cmd_q = 4'hf;
    repeat (100) @(negedge ref_clk_i);
    chk({5'h0, tx_info_o}, 8'h00);
    @(posedge ref_clk_i);
    clock_switch_off_bit_i <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk({7'h0, clk_stop_o}, 8'h00);
    $display("refusal test done");
    cmd_q = 4'h8;
    @(posedge ref_clk_i);
    {rx_info3_i, rx_sync_i} <= 2'h3;
    see(4'hc, 300, hit);
    chk({7'h0, hit}, 8'h01);
    for (int e = 0; e < 2; e++) begin
      @(posedge ref_clk_i);
      code_violation_enable_i <= e[0];
      rx_code_viol_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rx_code_viol_i <= 1'b0;
      see(4'hb, 100, hit);
      chk({7'h0, hit}, {7'h0, e[0]});
    end
    see(4'hc, 100, hit);
    chk({7'h0, hit}, 8'h01);
    $display("violation test done");
    // no quiet line, so only the long timer can end deactivation
    cmd_q = 4'h0;
    see(4'h0, 200, hit);
    chk({5'h0, tx_info_o}, 8'h00);
    see(4'hf, 400, hit);
    chk({7'h0, hit}, 8'h01);
    $display("timer test done");
    test_done();
  end
endmodule : stact_fsm_test
